// ==== esfu_pkg.sv ====
// Package with bit positions, reset values and widths of the upper error-status flags.
package esfu_pkg;
  localparam int FLAG_W = 7;
  localparam int FLAG_LSB = 4;
  localparam int BIT_THERMAL = 10;
  localparam int BIT_LOCK = 9;
  localparam int BIT_B_TABORT = 8;
  localparam int BIT_B_UNSC = 7;
  localparam int BIT_A_TABORT = 6;
  localparam int BIT_A_UNSC = 5;
  localparam int BIT_APERTURE = 4;
  localparam logic [6:0] FLAGS_RESET = 7'h00;
  // Flags allowed to raise a message; the lock flag (field bit 5) never does.
  localparam logic [6:0] MSG_CAPABLE = 7'h5f;
  localparam logic [1:0] SYNC_RESET = 2'h3;
endpackage

// ==== esfu_flags.sv ====
// Sticky error-status flags, bits 10 to 4, with message requests on rising flags other than the lock flag (bit 9).
// Function
// R1 - Thermal trip edge or overtemperature sets bit 10
// R2 - Locked cycle to non-DRAM sets bit 9
// R3 - Link B target abort sets bit 8
// R4 - Link B unimplemented special cycle sets bit 7
// R5 - Link A target abort sets bit 6
// R6 - Link A unimplemented special cycle sets bit 5
// R7 - Access outside aperture sets bit 4
// R8 - Flags stay set; write one clears
// R9 - Messages only when matching enable bit set
// R10 - Message raised only on zero-to-one transition
// R11 - Set wins over simultaneous clear
`timescale 1ns/1ps
module esfu_flags (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic THERMAL_TRIP_INPUT_N,
  input wire logic MEM_OVERTEMP,
  input wire logic LOCK_NONDRAM_EVT,
  input wire logic LINK_B_TABORT_EVT,
  input wire logic LINK_B_UNSC_EVT,
  input wire logic LINK_A_TABORT_EVT,
  input wire logic LINK_A_UNSC_EVT,
  input wire logic APERTURE_MISS_EVT,
  input wire logic CLEAR_WE,
  input wire logic [6:0] CLEAR_DATA,
  input wire logic [6:0] ERROR_MESSAGE_ENABLES,
  input wire logic [6:0] CONTROL_IRQ_ENABLES,
  input wire logic [6:0] SYSTEM_MGMT_IRQ_ENABLES,
  output logic [6:0] FLAGS,
  output logic SERR_MSG,
  output logic SCI_MSG,
  output logic SMI_MSG
);
  logic [1:0] trip_sync_r;
  logic trip_prev_r;
  logic [6:0] flags_r;
  logic [6:0] flags_nxt;
  logic [6:0] set_vec;
  logic [6:0] rise_vec;
  logic serr_r;
  logic sci_r;
  logic smi_r;
  logic thermal_set;

  // The trip pin is asynchronous; only the second stage is read by logic.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      trip_sync_r <= esfu_pkg::SYNC_RESET;
    end else begin
      trip_sync_r <= {trip_sync_r[0], THERMAL_TRIP_INPUT_N};
    end
  end

  // The previous level starts at the pin's idle high level, so reset release is no edge.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      trip_prev_r <= 1'b1;
    end else begin
      trip_prev_r <= trip_sync_r[1];
    end
  end

  // A trip is taken on a low-to-high change of the synchronised pin level.
  assign thermal_set = (~trip_prev_r & trip_sync_r[1]) | MEM_OVERTEMP; // [R1]

  // Maps a status register bit number onto its position in the 7-bit field.
  function automatic int flag_idx(input int status_bit);
    return status_bit - esfu_pkg::FLAG_LSB;
  endfunction

  always_comb begin
    set_vec = '0;
    set_vec[flag_idx(esfu_pkg::BIT_THERMAL)] = thermal_set; // [R1]
    set_vec[flag_idx(esfu_pkg::BIT_LOCK)] = LOCK_NONDRAM_EVT; // [R2]
    set_vec[flag_idx(esfu_pkg::BIT_B_TABORT)] = LINK_B_TABORT_EVT; // [R3]
    set_vec[flag_idx(esfu_pkg::BIT_B_UNSC)] = LINK_B_UNSC_EVT; // [R4]
    set_vec[flag_idx(esfu_pkg::BIT_A_TABORT)] = LINK_A_TABORT_EVT; // [R5]
    set_vec[flag_idx(esfu_pkg::BIT_A_UNSC)] = LINK_A_UNSC_EVT; // [R6]
    set_vec[flag_idx(esfu_pkg::BIT_APERTURE)] = APERTURE_MISS_EVT; // [R7]
  end

  // Clear first and OR the new events in after, so an error is never lost to a clear.
  always_comb begin
    flags_nxt = flags_r;
    if (CLEAR_WE) begin
      flags_nxt = flags_r & ~CLEAR_DATA; // [R8]
    end
    flags_nxt = flags_nxt | set_vec; // [R11]
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      flags_r <= esfu_pkg::FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Only a zero-to-one change counts; a flag held high stays quiet.
  assign rise_vec = flags_nxt & ~flags_r & esfu_pkg::MSG_CAPABLE; // [R10]

  // Registered requests cost one cycle but give the hub clean one-cycle pulses.

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      serr_r <= 1'b0;
      sci_r <= 1'b0;
      smi_r <= 1'b0;
    end else begin
      serr_r <= |(rise_vec & ERROR_MESSAGE_ENABLES); // [R9]
      sci_r <= |(rise_vec & CONTROL_IRQ_ENABLES); // [R9]
      smi_r <= |(rise_vec & SYSTEM_MGMT_IRQ_ENABLES); // [R9]
    end
  end

  assign FLAGS = flags_r;
  assign SERR_MSG = serr_r;
  assign SCI_MSG = sci_r;
  assign SMI_MSG = smi_r;

  a_link_b_set: assert property (@(posedge CLK) disable iff (!NRST) // [R3]
    LINK_B_TABORT_EVT |=> FLAGS[4]) else $error("link B abort flag not set");
  a_lock_set: assert property (@(posedge CLK) disable iff (!NRST) // [R2]
    LOCK_NONDRAM_EVT |=> FLAGS[5]) else $error("lock flag not set");
  a_aperture_set: assert property (@(posedge CLK) disable iff (!NRST) // [R7]
    APERTURE_MISS_EVT |=> FLAGS[0]) else $error("aperture flag not set");
  a_a_tabort_set: assert property (@(posedge CLK) disable iff (!NRST) // [R5]
    LINK_A_TABORT_EVT |=> FLAGS[2]) else $error("link A abort flag not set");
  a_unsc_set: assert property (@(posedge CLK) disable iff (!NRST) // [R4] [R6]
    (LINK_B_UNSC_EVT |=> FLAGS[3]) and (LINK_A_UNSC_EVT |=> FLAGS[1]))
    else $error("special cycle flag not set");
  sequence s_trip_edge;
    $rose(trip_sync_r[1]) ##1 1'b1;
  endsequence
  a_thermal_edge: assert property (@(posedge CLK) disable iff (!NRST) // [R1]
    s_trip_edge |-> FLAGS[6]) else $error("thermal flag missed trip");
  a_sticky_hold: assert property (@(posedge CLK) disable iff (!NRST) // [R8]
    (flags_r[3] && !(CLEAR_WE && CLEAR_DATA[3])) |=> flags_r[3])
    else $error("flag dropped without clear");
  a_clear_one: assert property (@(posedge CLK) disable iff (!NRST) // [R8]
    (CLEAR_WE && CLEAR_DATA[0] && !APERTURE_MISS_EVT) |=> !FLAGS[0])
    else $error("write one did not clear");
  a_serr_cause: assert property (@(posedge CLK) disable iff (!NRST) // [R9]
    SERR_MSG |-> $past(|(rise_vec & ERROR_MESSAGE_ENABLES)))
    else $error("serr without enabled rise");
  a_no_repeat: assert property (@(posedge CLK) disable iff (!NRST) // [R10]
    (rise_vec == 7'h00) |=> !(SERR_MSG || SCI_MSG || SMI_MSG))
    else $error("message while flag held");

  // Message requests are registered, so each check looks one cycle after the rise.
  sequence s_serr_due;
    |(rise_vec & ERROR_MESSAGE_ENABLES);
  endsequence
  sequence s_sci_due;
    |(rise_vec & CONTROL_IRQ_ENABLES);
  endsequence
  sequence s_smi_due;
    |(rise_vec & SYSTEM_MGMT_IRQ_ENABLES);
  endsequence
  sequence s_lock_only_rise;
    (flags_nxt & ~flags_r) == 7'h20;
  endsequence

  a_serr_raise: assert property (@(posedge CLK) disable iff (!NRST) // [R9]
    s_serr_due |=> SERR_MSG)
    else $error("enabled rise gave no serr");

  a_sci_raise: assert property (@(posedge CLK) disable iff (!NRST) // [R9]
    s_sci_due |=> SCI_MSG)
    else $error("enabled rise gave no sci");

  a_smi_raise: assert property (@(posedge CLK) disable iff (!NRST) // [R9]
    s_smi_due |=> SMI_MSG)
    else $error("enabled rise gave no smi");

  a_sci_cause: assert property (@(posedge CLK) disable iff (!NRST) // [R9]
    SCI_MSG |-> $past(|(rise_vec & CONTROL_IRQ_ENABLES)))
    else $error("sci without enabled rise");

  a_smi_cause: assert property (@(posedge CLK) disable iff (!NRST) // [R9]
    SMI_MSG |-> $past(|(rise_vec & SYSTEM_MGMT_IRQ_ENABLES)))
    else $error("smi without enabled rise");

  a_lock_silent: assert property (@(posedge CLK) disable iff (!NRST) // [R9]
    s_lock_only_rise |=> !(SERR_MSG || SCI_MSG || SMI_MSG))
    else $error("lock flag raised a message");

  // A set and a clear of the same flag in one cycle must leave it set.
  a_set_wins: assert property (@(posedge CLK) disable iff (!NRST) // [R11]
    (LINK_A_TABORT_EVT && CLEAR_WE && CLEAR_DATA[2]) |=> FLAGS[2])
    else $error("clear beat a link A abort");

  a_set_wins_heat: assert property (@(posedge CLK) disable iff (!NRST) // [R11]
    (MEM_OVERTEMP && CLEAR_WE && CLEAR_DATA[6]) |=> FLAGS[6])
    else $error("clear beat an overtemperature");

  a_thermal_level: assert property (@(posedge CLK) disable iff (!NRST) // [R1]
    MEM_OVERTEMP |=> FLAGS[6])
    else $error("overtemperature did not set flag");

  // A falling pin or a held level must not set the thermal flag.
  a_no_false_trip: assert property (@(posedge CLK) disable iff (!NRST) // [R1]
    (!MEM_OVERTEMP && !$rose(trip_sync_r[1]) && !flags_r[6]) |=> !flags_r[6])
    else $error("thermal flag set without trip");

  a_clear_lock: assert property (@(posedge CLK) disable iff (!NRST) // [R8]
    (CLEAR_WE && CLEAR_DATA[5] && !LOCK_NONDRAM_EVT) |=> !FLAGS[5])
    else $error("write one did not clear lock flag");

  a_clear_thermal: assert property (@(posedge CLK) disable iff (!NRST) // [R8]
    (CLEAR_WE && CLEAR_DATA[6] && !MEM_OVERTEMP && !$rose(trip_sync_r[1])) |=> !FLAGS[6])
    else $error("write one did not clear thermal flag");

  a_hold_lock: assert property (@(posedge CLK) disable iff (!NRST) // [R8]
    (flags_r[5] && !(CLEAR_WE && CLEAR_DATA[5])) |=> flags_r[5])
    else $error("lock flag dropped without clear");

  a_hold_thermal: assert property (@(posedge CLK) disable iff (!NRST) // [R8]
    (flags_r[6] && !(CLEAR_WE && CLEAR_DATA[6])) |=> flags_r[6])
    else $error("thermal flag dropped without clear");

  a_hold_aperture: assert property (@(posedge CLK) disable iff (!NRST) // [R8]
    (flags_r[0] && !(CLEAR_WE && CLEAR_DATA[0])) |=> flags_r[0])
    else $error("aperture flag dropped without clear");
endmodule // esfu_flags

// ==== esfu_hub_model.sv ====
// Far-side hub model that counts the error message pulses it receives.
`timescale 1ns/1ps
module esfu_hub_model (
  input wire logic CLK,
  input wire logic SERR_MSG,
  input wire logic SCI_MSG,
  input wire logic SMI_MSG
);
  logic [7:0] cnt [3] = '{default: 8'h00};
  always @(posedge CLK) begin
    cnt[0] <= cnt[0] + 8'(SERR_MSG);
    cnt[1] <= cnt[1] + 8'(SCI_MSG);
    cnt[2] <= cnt[2] + 8'(SMI_MSG);
  end
endmodule // esfu_hub_model

// ==== tb.sv ====
// Self-checking bench for the upper error-status flags.
`timescale 1ns/1ps
module tb;
  logic clk = 0, nrst = 0, pin_n = 1, cwe = 0;
  logic [6:0] ev = '0, cd = '0, en = '0, v, flags;
  logic serr, sci, smi;
  logic [7:0] e = '0;
  int mismatches = 0, n_compared = 0;
  esfu_flags uut (.CLK(clk), .NRST(nrst), .THERMAL_TRIP_INPUT_N(pin_n), .MEM_OVERTEMP(ev[6]),
    .LOCK_NONDRAM_EVT(ev[5]), .LINK_B_TABORT_EVT(ev[4]), .LINK_B_UNSC_EVT(ev[3]),
    .LINK_A_TABORT_EVT(ev[2]), .LINK_A_UNSC_EVT(ev[1]), .APERTURE_MISS_EVT(ev[0]),
    .CLEAR_WE(cwe), .CLEAR_DATA(cd), .ERROR_MESSAGE_ENABLES(en), .CONTROL_IRQ_ENABLES(en),
    .SYSTEM_MGMT_IRQ_ENABLES(en), .FLAGS(flags), .SERR_MSG(serr), .SCI_MSG(sci), .SMI_MSG(smi));
  esfu_hub_model hub (.CLK(clk), .SERR_MSG(serr), .SCI_MSG(sci), .SMI_MSG(smi));
  initial forever #25 clk = ~clk;
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle event and clear strobe; an idle cycle always follows before the next call.
  task automatic drive(logic [6:0] s, logic [6:0] c);
    @(posedge clk);
    ev <= s;
    cwe <= |c;
    cd <= c;
    @(posedge clk);
    ev <= '0;
    cwe <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    en <= 7'h7f;
    step(3);
    chk(flags, 7'h00);
    for (int i = 0; i < 7; i++) begin
      v = 7'h01 << i;
      drive(v, 7'h00);
      drive(v, ~v);
      step(3);
      e += 8'(esfu_pkg::MSG_CAPABLE[i]);
      chk(flags, v);
      chk({hub.cnt[0], hub.cnt[1], hub.cnt[2]}, {3{e}});
      drive(7'h00, v);
      step(1);
      chk(flags, 7'h00);
      drive(v, v);
      step(3);
      e += 8'(esfu_pkg::MSG_CAPABLE[i]);
      chk(flags, v);
      chk({hub.cnt[0], hub.cnt[1], hub.cnt[2]}, {3{e}});
      drive(7'h00, v);
    end
    en <= 7'h00;
    pin_n <= 1'b0;
    step(5);
    chk(flags, 7'h00);
    @(posedge clk);
    pin_n <= 1'b1;
    step(5);
    chk(flags, 7'h40);
    drive(7'h00, 7'h40);
    step(3);
    chk(flags, 7'h00);
    chk({hub.cnt[0], hub.cnt[1], hub.cnt[2]}, {3{e}});
    wrap_up();
  end
endmodule // tb
